// >>> design/dtl_top.v
`default_nettype none
`include "dtl_defines.vh"

// ----------------------------------------------------------------
// One 16-bit counter/timer
// ----------------------------------------------------------------
module dtl_counter (
   // Clock and reset
   input wire clk,
   input wire arst_n,
   // Counter clock events and gate
   input wire tick_rise,
   input wire tick_fall,
   input wire gate,
   // Programming
   input wire [2:0] mode,
   input wire load,
   input wire [15:0] load_val,
   // State
   output reg [15:0] count_reg,
   output reg out_reg
);
   reg [15:0] reload_reg;
   reg gate_q_reg;
   reg run_reg;
   wire [1:0] kind = mode[1:0];
   wire periodic = (kind == `DTL_M_RATE) || (kind == `DTL_M_SQUARE);
   // Periodic waveforms always step on the rising clock edge
   wire cnt_tick = (mode[`DTL_MODE_FALL] && !periodic) ? tick_fall :
                   tick_rise;
   wire [15:0] dec = count_reg - 16'h0001;

   // Gate sampled at counter clock rise; output changes at the counting edge or on load
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         count_reg <= 16'h0000;
         reload_reg <= 16'h0000;
         gate_q_reg <= 1'b0;
         run_reg <= 1'b0;
         out_reg <= 1'b0;
      end else begin
         if (tick_rise) begin
            gate_q_reg <= gate;
         end
         if (load) begin
            reload_reg <= load_val;
            count_reg <= load_val;
            run_reg <= 1'b0;
            out_reg <= periodic;
         end else begin
            // Edge-gated start on a low-to-high gate sample
            if (tick_rise && kind == `DTL_M_EDGE && gate && !gate_q_reg) begin
               run_reg <= 1'b1;
            end
            if (cnt_tick) begin
               case (kind)
                  `DTL_M_EVENT: begin
                     if (gate_q_reg) begin
                        count_reg <= dec;
                     end
                  end
                  `DTL_M_EDGE: begin
                     if (run_reg) begin
                        count_reg <= dec;
                        if (count_reg == 16'h0001) begin
                           out_reg <= 1'b1;
                        end
                     end
                  end
                  `DTL_M_RATE: begin
                     // Low for one period then reload: rising edge per cycle
                     if (gate_q_reg) begin
                        if (count_reg == 16'h0001) begin
                           count_reg <= reload_reg;
                           out_reg <= 1'b0;
                        end else begin
                           count_reg <= dec;
                           out_reg <= 1'b1;
                        end
                     end
                  end
                  default: begin
                     if (gate_q_reg) begin
                        if (count_reg == 16'h0001) begin
                           count_reg <= reload_reg;
                           out_reg <= ~out_reg;
                        end else begin
                           count_reg <= dec;
                        end
                     end
                  end
               endcase
            end
         end
      end
   end
endmodule // dtl_counter

// Behaviour
// - rising external trigger starts one conversion
// - sample written within 10 us of trigger
// - external trigger pin is input only
// - counter 0 paces sampling, trigger selectable instead
// - counter 0 on 1 MHz; counter 1 optional
// - counters 1,2 gate/clock/out pins; counter 0 gate/out
// - event count on chosen edge, readable anytime
// - event counting pauses while gate low
// - level-gated countdown only while gate high
// - edge-gated counting starts after gate rise
// - frequency mode counts falling edges under gate
// - counters generate pulse or square waveforms
// - gate sampled at clock rise, output updated at counting edge
// - host reads card info, then enables card
// - card enable gates register decode and strobes
// - data driven only on host reads
// - enabled pending causes merge onto interrupt line
// - FIFO threshold reached raises a cause
// - low external request raises a cause
// - counter 2 output rise raises a cause
// - each cause separately enabled and cleared
// - sample timer output rise starts conversion
// - sample timer pulses and reloads at a count of one
// - three independent 16-bit counters
module dtl_top (
   // Clock and reset
   input wire CLK,
   input wire ARST_N,
   // AXI4-Lite write address and data
   input wire [7:0] S_AXI_AWADDR,
   input wire S_AXI_AWVALID,
   output wire S_AXI_AWREADY,
   input wire [31:0] S_AXI_WDATA,
   input wire [3:0] S_AXI_WSTRB,
   input wire S_AXI_WVALID,
   output wire S_AXI_WREADY,
   // AXI4-Lite write response
   output reg [1:0] S_AXI_BRESP,
   output reg S_AXI_BVALID,
   input wire S_AXI_BREADY,
   // AXI4-Lite read
   input wire [7:0] S_AXI_ARADDR,
   input wire S_AXI_ARVALID,
   output wire S_AXI_ARREADY,
   output reg [31:0] S_AXI_RDATA,
   output reg [1:0] S_AXI_RRESP,
   output reg S_AXI_RVALID,
   input wire S_AXI_RREADY,
   // Connector timing pins
   input wire EXTERNAL_CONVERT_TRIGGER_N,
   input wire EXTERNAL_INTERRUPT_REQUEST_N,
   input wire GATE0,
   input wire GATE1,
   input wire GATE2,
   input wire CLK1_IN,
   input wire CLK2_IN,
   output wire SAMPLE_TIMER_OUTPUT,
   output wire OUT1,
   output wire OUT2,
   // Converter and sample FIFO
   output reg CONV_START,
   input wire ADC_DONE,
   input wire [11:0] ADC_DATA,
   output reg FIFO_WR,
   output reg [15:0] FIFO_DATA,
   input wire [9:0] FIFO_LEVEL,
   // Host interrupt
   output wire IREQ_N
);
   // ----------------------------------------------------------------
   // Input synchronisers
   // ----------------------------------------------------------------
   // Trigger and request pins idle high: no false edge or cause after reset
   localparam [6:0] SYNC_RST = 7'h03;
   localparam [31:0] CONV_FULL = `DTL_CONV_LIMIT_CYC - `DTL_SYNC_LAT - 1;
   localparam [31:0] TB_FULL = `DTL_TB_DIV - 1;
   // Cut to counter width on purpose
   localparam [9:0] CONV_END = CONV_FULL[9:0];
   localparam [6:0] TB_END = TB_FULL[6:0];
   localparam S_IDLE = 2'b01;
   localparam S_CONV = 2'b10;

   reg [6:0] sync1_reg;
   reg [6:0] sync2_reg;
   reg [6:0] prev_reg;
   // Bit order: trig, request, gate0..2, clk1, clk2
   wire [6:0] pins = {CLK2_IN, CLK1_IN, GATE2, GATE1, GATE0,
                      EXTERNAL_INTERRUPT_REQUEST_N,
                      EXTERNAL_CONVERT_TRIGGER_N};

   // Two flops before any edge or level use
   always @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         sync1_reg <= SYNC_RST;
         sync2_reg <= SYNC_RST;
         prev_reg <= SYNC_RST;
      end else begin
         sync1_reg <= pins;
         sync2_reg <= sync1_reg;
         prev_reg <= sync2_reg;
      end
   end
   wire [6:0] rise = sync2_reg & ~prev_reg;
   wire [6:0] fall = ~sync2_reg & prev_reg;

   // ----------------------------------------------------------------
   // 1 MHz timebase
   // ----------------------------------------------------------------
   reg [6:0] tb_cnt_reg;
   wire tb_tick = (tb_cnt_reg == TB_END);

   // Divider, never driven out to the connector
   always @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         tb_cnt_reg <= 7'h00;
      end else if (tb_tick) begin
         tb_cnt_reg <= 7'h00;
      end else begin
         tb_cnt_reg <= tb_cnt_reg + 7'h01;
      end
   end

   // ----------------------------------------------------------------
   // Registers and bus slave
   // ----------------------------------------------------------------
   reg [2:0] ctrl_reg;
   reg [2:0] irq_en_reg;
   reg [2:0] irq_stat_reg;
   reg [9:0] thresh_reg;
   reg [2:0] mode0_reg;
   reg [2:0] mode1_reg;
   reg [2:0] mode2_reg;
   reg late_reg;
   reg aw_hold_reg;
   reg w_hold_reg;
   reg [7:0] awaddr_reg;
   reg [31:0] wdata_reg;
   reg [3:0] wstrb_reg;
   reg [31:0] rd_data;
   reg [1:0] rd_resp;
   wire [15:0] cnt0;
   wire [15:0] cnt1;
   wire [15:0] cnt2;
   wire sample_timer_output;
   wire out1;
   wire out2;
   wire busy;

   assign S_AXI_AWREADY = !aw_hold_reg;
   assign S_AXI_WREADY = !w_hold_reg;
   assign S_AXI_ARREADY = !S_AXI_RVALID;

   function [31:0] merge;
      input [31:0] old;
      input [31:0] d;
      input [3:0] s;
      begin
         merge = (old & ~{{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}}) |
                 (d & {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}});
      end
   endfunction

   function mapped;
      input [7:0] a;
      begin
         mapped = (a[1:0] == 2'b00) && (a <= `DTL_OFF_STATUS);
      end
   endfunction

   wire card_en = ctrl_reg[`DTL_CTRL_CARD_EN];
   // Disabled card answers only its configuration register
   wire wr_fire = aw_hold_reg && w_hold_reg && !S_AXI_BVALID;
   wire wr_ok = mapped(awaddr_reg) &&
                (card_en || awaddr_reg == `DTL_OFF_CTRL);
   wire wr_en = wr_fire && wr_ok;
   wire [31:0] wm = merge(32'h00000000, wdata_reg, wstrb_reg);
   wire ld0 = wr_en && awaddr_reg == `DTL_OFF_CNT0;
   wire ld1 = wr_en && awaddr_reg == `DTL_OFF_CNT1;
   wire ld2 = wr_en && awaddr_reg == `DTL_OFF_CNT2;
   wire [31:0] ld0_val = merge({16'h0000, cnt0}, wdata_reg, wstrb_reg);
   wire [31:0] ld1_val = merge({16'h0000, cnt1}, wdata_reg, wstrb_reg);
   wire [31:0] ld2_val = merge({16'h0000, cnt2}, wdata_reg, wstrb_reg);
   wire [31:0] ctrl_m = merge({29'h0, ctrl_reg}, wdata_reg, wstrb_reg);
   wire [31:0] ien_m = merge({29'h0, irq_en_reg}, wdata_reg, wstrb_reg);
   wire [31:0] thr_m = merge({22'h0, thresh_reg}, wdata_reg, wstrb_reg);

   // Write channel: address and data captured in either order
   always @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         aw_hold_reg <= 1'b0;
         w_hold_reg <= 1'b0;
         awaddr_reg <= 8'h00;
         wdata_reg <= 32'h00000000;
         wstrb_reg <= 4'h0;
         S_AXI_BVALID <= 1'b0;
         S_AXI_BRESP <= `DTL_RESP_OKAY;
         ctrl_reg <= `DTL_CTRL_RST;
         irq_en_reg <= 3'h0;
         thresh_reg <= `DTL_THRESH_RST;
         mode0_reg <= `DTL_MODE_RST;
         mode1_reg <= `DTL_MODE_RST;
         mode2_reg <= `DTL_MODE_RST;
      end else begin
         if (S_AXI_AWVALID && !aw_hold_reg) begin
            aw_hold_reg <= 1'b1;
            awaddr_reg <= S_AXI_AWADDR;
         end
         if (S_AXI_WVALID && !w_hold_reg) begin
            w_hold_reg <= 1'b1;
            wdata_reg <= S_AXI_WDATA;
            wstrb_reg <= S_AXI_WSTRB;
         end
         if (wr_fire) begin
            aw_hold_reg <= 1'b0;
            w_hold_reg <= 1'b0;
            S_AXI_BVALID <= 1'b1;
            if (!mapped(awaddr_reg)) begin
               S_AXI_BRESP <= `DTL_RESP_DECERR;
            end else if (!wr_ok) begin
               S_AXI_BRESP <= `DTL_RESP_SLVERR;
            end else begin
               S_AXI_BRESP <= `DTL_RESP_OKAY;
            end
         end else if (S_AXI_BREADY) begin
            S_AXI_BVALID <= 1'b0;
         end
         if (wr_en) begin
            case (awaddr_reg)
               `DTL_OFF_CTRL: ctrl_reg <= ctrl_m[2:0];
               `DTL_OFF_IRQ_EN: irq_en_reg <= ien_m[2:0];
               `DTL_OFF_THRESH: thresh_reg <= thr_m[9:0];
               `DTL_OFF_MODE0: mode0_reg <= wm[2:0];
               `DTL_OFF_MODE1: mode1_reg <= wm[2:0];
               `DTL_OFF_MODE2: mode2_reg <= wm[2:0];
               default: ;
            endcase
         end
      end
   end

   // Read decode; data appears only with a read answer
   always @* begin
      rd_data = 32'h00000000;
      rd_resp = `DTL_RESP_OKAY;
      if (!mapped(S_AXI_ARADDR)) begin
         rd_resp = `DTL_RESP_DECERR;
      end else if (!card_en && S_AXI_ARADDR != `DTL_OFF_CTRL) begin
         rd_resp = `DTL_RESP_SLVERR;
      end else begin
         case (S_AXI_ARADDR)
            `DTL_OFF_CTRL: rd_data = {29'h0, ctrl_reg};
            `DTL_OFF_IRQ_EN: rd_data = {29'h0, irq_en_reg};
            `DTL_OFF_IRQ_STAT: rd_data = {29'h0, irq_stat_reg};
            `DTL_OFF_THRESH: rd_data = {22'h0, thresh_reg};
            `DTL_OFF_LEVEL: rd_data = {22'h0, FIFO_LEVEL};
            `DTL_OFF_MODE0: rd_data = {29'h0, mode0_reg};
            `DTL_OFF_MODE1: rd_data = {29'h0, mode1_reg};
            `DTL_OFF_MODE2: rd_data = {29'h0, mode2_reg};
            `DTL_OFF_CNT0: rd_data = {16'h0, cnt0};
            `DTL_OFF_CNT1: rd_data = {16'h0, cnt1};
            `DTL_OFF_CNT2: rd_data = {16'h0, cnt2};
            default: rd_data = {26'h0, out2, out1, sample_timer_output,
                                ~sync2_reg[1], late_reg, busy};
         endcase
      end
   end

   // Read channel, answer one cycle after the address is taken
   always @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         S_AXI_RVALID <= 1'b0;
         S_AXI_RDATA <= 32'h00000000;
         S_AXI_RRESP <= `DTL_RESP_OKAY;
      end else if (S_AXI_ARVALID && !S_AXI_RVALID) begin
         S_AXI_RVALID <= 1'b1;
         S_AXI_RDATA <= rd_data;
         S_AXI_RRESP <= rd_resp;
      end else if (S_AXI_RREADY) begin
         S_AXI_RVALID <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Counter/timers
   // ----------------------------------------------------------------
   wire c1_int = ctrl_reg[`DTL_CTRL_C1_INT_CLK];

   // Counter 0 has no clock pin: timebase only
   dtl_counter u_cnt0 (
      .clk(CLK),
      .arst_n(ARST_N),
      .tick_rise(tb_tick),
      .tick_fall(tb_tick),
      .gate(sync2_reg[2]),
      .mode(mode0_reg),
      .load(ld0),
      .load_val(ld0_val[15:0]),
      .count_reg(cnt0),
      .out_reg(sample_timer_output)
   );

   dtl_counter u_cnt1 (
      .clk(CLK),
      .arst_n(ARST_N),
      .tick_rise(c1_int ? tb_tick : rise[5]),
      .tick_fall(c1_int ? tb_tick : fall[5]),
      .gate(sync2_reg[3]),
      .mode(mode1_reg),
      .load(ld1),
      .load_val(ld1_val[15:0]),
      .count_reg(cnt1),
      .out_reg(out1)
   );

   dtl_counter u_cnt2 (
      .clk(CLK),
      .arst_n(ARST_N),
      .tick_rise(rise[6]),
      .tick_fall(fall[6]),
      .gate(sync2_reg[4]),
      .mode(mode2_reg),
      .load(ld2),
      .load_val(ld2_val[15:0]),
      .count_reg(cnt2),
      .out_reg(out2)
   );

   assign SAMPLE_TIMER_OUTPUT = sample_timer_output;
   assign OUT1 = out1;
   assign OUT2 = out2;

   // ----------------------------------------------------------------
   // Conversion sequencer
   // ----------------------------------------------------------------
   reg sample_timer_output_prev_reg;
   reg out2_prev_reg;
   reg [1:0] state_reg;
   reg [9:0] wait_reg;
   wire ext_sel = ctrl_reg[`DTL_CTRL_EXT_TRIG];
   // Trigger arriving while a conversion is busy is dropped
   wire start = ext_sel ? rise[0] :
                (sample_timer_output & ~sample_timer_output_prev_reg);
   assign busy = state_reg[1];

   // Deadline forces the sample in even if the converter is slow
   always @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         state_reg <= S_IDLE;
         wait_reg <= 10'h000;
         CONV_START <= 1'b0;
         FIFO_WR <= 1'b0;
         FIFO_DATA <= 16'h0000;
         late_reg <= 1'b0;
         sample_timer_output_prev_reg <= 1'b0;
         out2_prev_reg <= 1'b0;
      end else begin
         sample_timer_output_prev_reg <= sample_timer_output;
         out2_prev_reg <= out2;
         CONV_START <= 1'b0;
         FIFO_WR <= 1'b0;
         if (wr_en && awaddr_reg == `DTL_OFF_STATUS && wm[1]) begin
            late_reg <= 1'b0;
         end
         case (state_reg)
            S_IDLE: begin
               if (start) begin
                  CONV_START <= 1'b1;
                  wait_reg <= 10'h000;
                  state_reg <= S_CONV;
               end
            end
            S_CONV: begin
               wait_reg <= wait_reg + 10'h001;
               if (ADC_DONE || wait_reg == CONV_END) begin
                  FIFO_WR <= 1'b1;
                  FIFO_DATA <= {{4{ADC_DATA[11]}}, ADC_DATA};
                  state_reg <= S_IDLE;
                  if (!ADC_DONE) begin
                     late_reg <= 1'b1;
                  end
               end
            end
            default: state_reg <= S_IDLE;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Interrupt causes
   // ----------------------------------------------------------------
   wire [2:0] irq_set;
   wire [2:0] irq_clr = (wr_en && awaddr_reg == `DTL_OFF_IRQ_STAT) ?
                        wm[2:0] : 3'h0;
   assign irq_set[`DTL_IRQ_FIFO] = (thresh_reg != 10'h000) &&
                                   (FIFO_LEVEL >= thresh_reg);
   assign irq_set[`DTL_IRQ_EXT] = ~sync2_reg[1];
   assign irq_set[`DTL_IRQ_C2] = out2 & ~out2_prev_reg;

   // Sticky; a new event beats a simultaneous clear
   always @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         irq_stat_reg <= 3'h0;
      end else begin
         irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_set;
      end
   end

   assign IREQ_N = ~|(irq_stat_reg & irq_en_reg);
endmodule // dtl_top

`default_nettype wire

// >>> design/dtl_defines.vh
`ifndef DTL_DEFINES_VH
`define DTL_DEFINES_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define DTL_ADDR_W 8
`define DTL_OFF_CTRL 8'h00
`define DTL_OFF_IRQ_EN 8'h04
`define DTL_OFF_IRQ_STAT 8'h08
`define DTL_OFF_THRESH 8'h0C
`define DTL_OFF_LEVEL 8'h10
`define DTL_OFF_MODE0 8'h14
`define DTL_OFF_MODE1 8'h18
`define DTL_OFF_MODE2 8'h1C
`define DTL_OFF_CNT0 8'h20
`define DTL_OFF_CNT1 8'h24
`define DTL_OFF_CNT2 8'h28
`define DTL_OFF_STATUS 8'h2C

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define DTL_CTRL_CARD_EN 0
`define DTL_CTRL_EXT_TRIG 1
`define DTL_CTRL_C1_INT_CLK 2
`define DTL_CTRL_RST 3'h0
`define DTL_MODE_FALL 2
`define DTL_MODE_RST 3'h0
`define DTL_IRQ_FIFO 0
`define DTL_IRQ_EXT 1
`define DTL_IRQ_C2 2
`define DTL_THRESH_RST 10'h000

// ----------------------------------------------------------------
// Counter modes
// ----------------------------------------------------------------
`define DTL_M_EVENT 2'h0
`define DTL_M_EDGE 2'h1
`define DTL_M_RATE 2'h2
`define DTL_M_SQUARE 2'h3

// ----------------------------------------------------------------
// Bus responses
// ----------------------------------------------------------------
`define DTL_RESP_OKAY 2'h0
`define DTL_RESP_SLVERR 2'h2
`define DTL_RESP_DECERR 2'h3

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define DTL_CLK_HZ 100000000
`define DTL_CLK_NS 10
`define DTL_TB_HZ 1000000
`define DTL_TB_DIV (`DTL_CLK_HZ / `DTL_TB_HZ)
`define DTL_CONV_LIMIT_NS 10000
`define DTL_CONV_LIMIT_CYC (`DTL_CONV_LIMIT_NS / `DTL_CLK_NS)
`define DTL_SYNC_LAT 3

`endif

// >>> tb/dtl_top_props.sv
`default_nettype none
module dtl_chk (
   // Clock and reset
   input wire logic CLK,
   input wire logic ARST_N,
   // Register bus
   input wire logic S_AXI_ARVALID,
   input wire logic S_AXI_ARREADY,
   input wire logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY,
   input wire logic [31:0] S_AXI_RDATA,
   input wire logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   // Converter, FIFO, interrupt
   input wire logic CONV_START,
   input wire logic FIFO_WR,
   input wire logic [15:0] FIFO_DATA,
   input wire logic IREQ_N
);
   timeunit 1ns;
   timeprecision 100ps;
   // ------
   // Port relations
   // ------
   default clocking @(posedge CLK); endclocking
   default disable iff (!ARST_N);
   a_conv_pulse: assert property (CONV_START |=> !CONV_START)
      else $error("start pulse too long");
   a_wr_pulse: assert property (FIFO_WR |=> !FIFO_WR)
      else $error("fifo write pulse too long");
   // Forced write at the timeout keeps this bound even with no done
   a_conv_to_fifo: assert property (CONV_START |-> ##[1:1000] FIFO_WR)
      else $error("sample not written in time");
   a_sign_ext: assert property (FIFO_WR |->
      FIFO_DATA[15:12] == {4{FIFO_DATA[11]}})
      else $error("sample not sign extended");
   a_read_answer: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=>
      S_AXI_RVALID)
      else $error("read not answered");
   a_read_hold: assert property (S_AXI_RVALID && !S_AXI_RREADY |=>
      S_AXI_RVALID && $stable(S_AXI_RDATA))
      else $error("read data dropped");
   a_ar_block: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
      else $error("read address taken while busy");
   a_resp_hold: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID)
      else $error("write response dropped");
   // A clear or enable write lands at the edge where the response rises
   a_irq_pending: assert property (!IREQ_N |=>
      !IREQ_N || $rose(S_AXI_BVALID))
      else $error("interrupt lost without clear");
endmodule // dtl_chk

bind dtl_top dtl_chk u_chk (.CLK(CLK), .ARST_N(ARST_N),
   .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
   .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY),
   .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_BVALID(S_AXI_BVALID),
   .S_AXI_BREADY(S_AXI_BREADY), .CONV_START(CONV_START),
   .FIFO_WR(FIFO_WR), .FIFO_DATA(FIFO_DATA), .IREQ_N(IREQ_N));
`default_nettype wire

// >>> tb/dtl_adc_model.sv
`default_nettype none
module dtl_adc_model (
   // Clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // Converter side
   input wire logic conv_start,
   input wire logic slow,
   input wire logic [11:0] sample,
   output logic adc_done,
   output logic [11:0] adc_data,
   // Sample FIFO side
   input wire logic fifo_wr,
   output logic [9:0] fifo_level
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [3:0] wait_cnt;
   // Data toggles outside done so a stale value never passes
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         wait_cnt <= 4'h0;
         adc_done <= 1'b0;
         adc_data <= 12'h000;
         fifo_level <= 10'h000;
      end else begin
         adc_done <= (wait_cnt == 4'h1);
         adc_data <= (wait_cnt == 4'h1) ? sample : ~adc_data;
         if (conv_start) wait_cnt <= slow ? 4'hF : 4'h2;
         else if (wait_cnt != 4'h0) wait_cnt <= wait_cnt - 4'h1;
         if (fifo_wr) fifo_level <= fifo_level + 10'h001;
      end
   end
endmodule // dtl_adc_model
`default_nettype wire

// >>> tb/tb_top.sv
`default_nettype none
`define CHK(a, e) begin x_got = a; x_exp = e; checks_done++; \
   if (x_got !== x_exp) begin err_total++; \
   $display("unexpected t=%0t got %0h exp %0h", $time, x_got, x_exp); end end
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk = 0, arst_n = 0, awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
   logic trg_n = 1, req_n = 1, g0 = 0, g1 = 0, g2 = 0, c1 = 0, c2 = 0;
   logic slow = 0;
   logic [7:0] awa = 0, ara = 0;
   logic [31:0] wd = 0, lfsr = 32'hE89E;
   logic [11:0] smp = 0;
   logic [33:0] x_got, x_exp, qr[$];
   logic [1:0] qb[$];
   logic [15:0] qf[$];
   int err_total = 0, checks_done = 0;
   wire awr, wrdy, bv, arr, rv, cs, done, fwr, irq_n;
   wire [1:0] bresp, rresp;
   wire [31:0] rdata;
   wire [11:0] adat;
   wire [15:0] fdat;
   wire [9:0] flev;
   wire o0, o1, o2;
   // ------
   // Design and converter model
   // ------
   dtl_top DUT (.CLK(clk), .ARST_N(arst_n), .S_AXI_AWADDR(awa),
      .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd),
      .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wv), .S_AXI_WREADY(wrdy),
      .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv), .S_AXI_BREADY(br),
      .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
      .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv),
      .S_AXI_RREADY(rr), .EXTERNAL_CONVERT_TRIGGER_N(trg_n),
      .EXTERNAL_INTERRUPT_REQUEST_N(req_n), .GATE0(g0), .GATE1(g1),
      .GATE2(g2), .CLK1_IN(c1), .CLK2_IN(c2), .SAMPLE_TIMER_OUTPUT(o0),
      .OUT1(o1), .OUT2(o2), .CONV_START(cs), .ADC_DONE(done),
      .ADC_DATA(adat), .FIFO_WR(fwr), .FIFO_DATA(fdat),
      .FIFO_LEVEL(flev), .IREQ_N(irq_n));
   dtl_adc_model u_adc (.clk(clk), .arst_n(arst_n), .conv_start(cs),
      .slow(slow), .sample(smp), .adc_done(done), .adc_data(adat),
      .fifo_wr(fwr), .fifo_level(flev));
   always #5 clk = ~clk;
   // Scoreboard: sampled at negedge, one half cycle before handshake
   always @(negedge clk) begin
      if (bv && br) `CHK(bresp, qb.pop_front())
      if (rv && rr) `CHK({rresp, rdata}, qr.pop_front())
      if (fwr) `CHK(fdat, qf.pop_front())
   end
   function logic [31:0] nxt(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction
   task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      logic ta, td, tr;
      qb.push_back(r);
      awa <= a; wd <= d; awv <= 1'b1; wv <= 1'b1; br <= 1'b1;
      forever begin
         @(negedge clk);
         ta = awv && awr; td = wv && wrdy; tr = bv;
         @(posedge clk);
         if (ta) awv <= 1'b0;
         if (td) wv <= 1'b0;
         if (tr) break;
      end
   endtask
   task rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      logic ta, tr;
      qr.push_back({r, d});
      ara <= a; arv <= 1'b1; rr <= 1'b1;
      forever begin
         @(negedge clk);
         ta = arv && arr; tr = rv;
         @(posedge clk);
         if (ta) arv <= 1'b0;
         if (tr) break;
      end
   endtask
   // Counter clocks kept well below a quarter of the system clock
   task pulses(input int k, input logic two);
      repeat (k) begin
         repeat (4) @(posedge clk);
         if (two) c2 <= 1'b1; else c1 <= 1'b1;
         repeat (4) @(posedge clk);
         if (two) c2 <= 1'b0; else c1 <= 1'b0;
      end
      repeat (8) @(posedge clk);
   endtask
   task wait_fifo;
      for (int n = 0; n < 1000 && qf.size() != 0; n++) @(posedge clk);
      `CHK(qf.size(), 0)
   endtask
   task test_done;
      $display("checks %0d errors %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   initial begin
      #400000;
      err_total++;
      test_done;
   end
   initial begin
      repeat (2) @(posedge clk);
      arst_n <= 1'b1;
      @(posedge clk);
      rd(8'h00, 0, 2'h0);
      rd(8'h04, 0, 2'h2);
      wr(8'h04, 7, 2'h2);
      wr(8'h00, 3, 2'h0);
      rd(8'h04, 0, 2'h0);
      rd(8'h30, 0, 2'h3);
      $display("test bus done");
      for (int i = 0; i < 4; i++) begin
         lfsr = nxt(lfsr);
         smp <= lfsr[11:0];
         slow <= i[0];
         qf.push_back({{4{lfsr[11]}}, lfsr[11:0]});
         trg_n <= 1'b0;
         repeat (5) @(posedge clk);
         trg_n <= 1'b1;
         wait_fifo;
      end
      $display("test trigger done");
      smp <= 12'h800;
      g0 <= 1'b1;
      wr(8'h14, 2, 2'h0);
      wr(8'h20, 3, 2'h0);
      @(negedge clk);
      `CHK(o0, 1'b1)
      @(posedge clk);
      qf.push_back(16'hF800);
      qf.push_back(16'hF800);
      wr(8'h00, 1, 2'h0);
      wait_fifo;
      wr(8'h00, 3, 2'h0);
      g0 <= 1'b0;
      $display("test timer done");
      // Third pass is edge gated: keeps counting once the gate drops
      for (int m = 0; m < 3; m++) begin
         wr(8'h18, (m == 2) ? 1 : m * 4, 2'h0);
         wr(8'h24, 16'h0010, 2'h0);
         g1 <= 1'b1;
         pulses(5, 1'b0);
         g1 <= 1'b0;
         pulses(3, 1'b0);
         rd(8'h24, (m == 2) ? 16'h0009 : 16'h000B, 2'h0);
      end
      wr(8'h00, 7, 2'h0);
      wr(8'h18, 3, 2'h0);
      wr(8'h24, 2, 2'h0);
      g1 <= 1'b1;
      @(negedge clk);
      `CHK(o1, 1'b1)
      repeat (350) @(posedge clk);
      @(negedge clk);
      `CHK(o1, 1'b0)
      @(posedge clk);
      $display("test count done");
      wr(8'h04, 7, 2'h0);
      req_n <= 1'b0;
      repeat (8) @(posedge clk);
      req_n <= 1'b1;
      wr(8'h1C, 3, 2'h0);
      wr(8'h28, 2, 2'h0);
      g2 <= 1'b1;
      pulses(6, 1'b1);
      rd(8'h08, 6, 2'h0);
      @(negedge clk);
      `CHK(irq_n, 1'b0)
      `CHK(o2, 1'b1)
      @(posedge clk);
      wr(8'h08, 2, 2'h0);
      rd(8'h08, 4, 2'h0);
      wr(8'h04, 3, 2'h0);
      @(negedge clk);
      `CHK(irq_n, 1'b1)
      @(posedge clk);
      rd(8'h08, 4, 2'h0);
      wr(8'h08, 4, 2'h0);
      rd(8'h08, 0, 2'h0);
      wr(8'h0C, 1, 2'h0);
      rd(8'h08, 1, 2'h0);
      rd(8'h10, 6, 2'h0);
      $display("test interrupt done");
      test_done;
   end
endmodule // tb_top
`default_nettype wire
